//--- src/lbus_params.svh
`ifndef LBUS_PARAMS_SVH
`define LBUS_PARAMS_SVH
// widths
`define OFF_W 15
`define SADR_W 12
`define CNT_W 8
// timer defaults in clk_sys_i cycles
`define LAT_CYC_DEF 8'h10
`define WAIT_CYC_DEF 8'h20
// page field offset[14:13]
`define PAGE_0 2'h0
`define PAGE_1 2'h1
`define PAGE_2 2'h2
`define PAGE_BAD 2'h3
// active-low byte enable codes
`define BE_B0 4'hE
`define BE_B1 4'hD
`define BE_B2 4'hB
`define BE_B3 4'h7
`define BE_LO 4'hC
`define BE_HI 4'h3
`endif

//--- src/lbus_pkg.sv
`include "lbus_params.svh"
package lbus_pkg;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic rdy_n;
    logic hlda;
    logic [12:0] addr;
    logic [15:0] data;
  } pin_in_t;
  typedef struct packed {
    logic write;
    logic [`OFF_W-1:0] off;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } mreq_t;
  typedef struct packed {
    logic ok;
    logic [1:0] la;
    logic bhe_n;
    logic hi;
    logic wide;
  } be_map_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_ACC = 4'b0010, S_RDY = 4'b0100, S_END = 4'b1000
  } slave_state_t;
  typedef enum logic [4:0] {
    M_IDLE = 5'b00001, M_HOLD = 5'b00010, M_ADDR = 5'b00100,
    M_STRB = 5'b01000, M_DONE = 5'b10000
  } master_state_t;
endpackage : lbus_pkg

//--- src/local_bus_sep_strobe_port.sv
`timescale 1ns/1ps
`include "lbus_params.svh"
// Behaviour
// - local clock output is the system clock fed straight through.
// - master cycles only run while local_master_enable is set.
// - second window disabled from reset until its enable bit is set.
// - offset pages 0/1/2 select cs1, cs2, both; page 3 invalid.
// - slave accesses are 16-bit, address from lines 12:1, data 15:0.
// - device drives read data after register access and pulls ready low in the same cycle.
// - strobe release: data tri-stated, ready high; ready tri-stated on select release.
// - back-to-back slave cycles allowed with slave select held low.
// - each valid window hit starts arbitration by raising hold request.
// - on hold acknowledge, latency timer starts and master cycle begins.
// - hold stays up while the cycle runs or latency timer unexpired.
// - master presents address, byte-high-enable, chip selects, then strobe.
// - master cycle ends on ready low or wait-state timer expiry.
// - 8-bit mode: single bytes map to address 00..11, low lane, bhe high.
// - illegal byte enables on an enabled window hit run no cycle and raise an access error.
module local_bus_sep_strobe_port import lbus_pkg::*; #(
  parameter logic [`CNT_W-1:0] LAT_CYC = `LAT_CYC_DEF,
  parameter logic [`CNT_W-1:0] WAIT_CYC = `WAIT_CYC_DEF
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // configuration
  input wire logic local_master_enable_i,
  input wire logic second_window_enable_i,
  input wire logic port_16bit_i,
  // pci side single access
  input wire logic pci_req_valid_i,
  output logic pci_req_ready_o,
  input wire logic pci_window_hit_i,
  input wire logic pci_write_i,
  input wire logic [`OFF_W-1:0] pci_offset_i,
  input wire logic [3:0] pci_be_n_i,
  input wire logic [31:0] pci_wdata_i,
  output logic pci_rsp_valid_o,
  output logic pci_rsp_err_o,
  output logic pci_rsp_timeout_o,
  output logic [31:0] pci_rdata_o,
  output logic access_error_o,
  // internal register port
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [`SADR_W-1:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_ack_i,
  // local bus pins
  output logic local_clock_out_o,
  input wire logic slave_chip_select_n_i,
  input wire logic read_strobe_n_i,
  output logic read_strobe_n_o,
  output logic read_strobe_n_oe_o,
  input wire logic write_strobe_n_i,
  output logic write_strobe_n_o,
  output logic write_strobe_n_oe_o,
  input wire logic local_ready_n_i,
  output logic local_ready_n_o,
  output logic local_ready_n_oe_o,
  input wire logic [12:0] local_address_i,
  output logic [12:0] local_address_o,
  output logic local_address_oe_o,
  input wire logic [15:0] local_data_i,
  output logic [15:0] local_data_o,
  output logic local_data_oe_o,
  output logic hold_request_o,
  input wire logic hold_acknowledge_i,
  output logic byte_high_enable_n_o,
  output logic page_chip_select_1_n_o,
  output logic page_chip_select_2_n_o
);

  assign local_clock_out_o = clk_sys_i;

  // ==========================================================
  // pin synchronisers
  pin_in_t pin_now;
  pin_in_t sync1_reg;
  pin_in_t sync2_reg;
  assign pin_now = '{cs_n: slave_chip_select_n_i, rd_n: read_strobe_n_i,
                     wr_n: write_strobe_n_i, rdy_n: local_ready_n_i,
                     hlda: hold_acknowledge_i, addr: local_address_i,
                     data: local_data_i};
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= pin_now;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // slave port
  slave_state_t s_reg, s_next;
  logic s_rd_reg, s_rd_next;
  logic rrd_reg, rrd_next;
  logic rwr_reg, rwr_next;
  logic [`SADR_W-1:0] radr_reg, radr_next;
  logic [15:0] rwd_reg, rwd_next;
  logic [15:0] sdo_reg, sdo_next;
  logic s_doe;

  always_comb begin
    s_next = s_reg;
    s_rd_next = s_rd_reg;
    rrd_next = 1'b0;
    rwr_next = 1'b0;
    radr_next = radr_reg;
    rwd_next = rwd_reg;
    sdo_next = sdo_reg;
    case (s_reg)
      S_IDLE: begin
        // exactly one strobe under a held select starts a cycle
        if (!sync2_reg.cs_n && (sync2_reg.rd_n != sync2_reg.wr_n)) begin
          s_rd_next = !sync2_reg.rd_n;
          rrd_next = !sync2_reg.rd_n;
          rwr_next = !sync2_reg.wr_n;
          radr_next = sync2_reg.addr[12:1];
          rwd_next = sync2_reg.data;
          s_next = S_ACC;
        end
      end
      S_ACC: begin
        if (reg_ack_i) begin
          sdo_next = reg_rdata_i;
          s_next = S_RDY;
        end
      end
      S_RDY: begin
        if (sync2_reg.cs_n || (sync2_reg.rd_n && sync2_reg.wr_n)) begin
          s_next = S_END;
        end
      end
      S_END: s_next = S_IDLE;
      default: s_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= S_IDLE;
      s_rd_reg <= 1'b0;
      rrd_reg <= 1'b0;
      rwr_reg <= 1'b0;
      radr_reg <= '0;
      rwd_reg <= '0;
      sdo_reg <= '0;
    end else begin
      s_reg <= s_next;
      s_rd_reg <= s_rd_next;
      rrd_reg <= rrd_next;
      rwr_reg <= rwr_next;
      radr_reg <= radr_next;
      rwd_reg <= rwd_next;
      sdo_reg <= sdo_next;
    end
  end

  assign reg_rd_o = rrd_reg;
  assign reg_wr_o = rwr_reg;
  assign reg_addr_o = radr_reg;
  assign reg_wdata_o = rwd_reg;
  assign s_doe = (s_reg == S_RDY) && s_rd_reg;
  assign local_ready_n_o = (s_reg != S_RDY);
  assign local_ready_n_oe_o = !sync2_reg.cs_n;

  // ==========================================================
  // master port
  function automatic be_map_t be_map(input logic [3:0] be_n, input logic w16);
    be_map_t m;
    m = '{ok: 1'b1, la: 2'h0, bhe_n: 1'b1, hi: 1'b0, wide: 1'b0};
    case (be_n)
      `BE_B0: m.la = 2'h0;
      `BE_B1: m.la = 2'h1;
      `BE_B2: m.la = 2'h2;
      `BE_B3: m.la = 2'h3;
      `BE_LO: m.wide = 1'b1;
      `BE_HI: begin
        m.wide = 1'b1;
        m.la = 2'h2;
      end
      default: m.ok = 1'b0;
    endcase
    if (!w16) begin
      m.ok = m.ok && !m.wide;
    end else begin
      m.hi = m.la[0] && !m.wide;
      m.bhe_n = !(m.la[0] || m.wide);
    end
    return m;
  endfunction : be_map

  master_state_t m_reg, m_next;
  mreq_t mreq_reg, mreq_next;
  be_map_t map_now, map_reg, map_next;
  logic [`CNT_W-1:0] lat_reg, lat_next;
  logic [`CNT_W-1:0] wait_reg, wait_next;
  logic [12:0] la_reg, la_next;
  logic [15:0] ldo_reg, ldo_next;
  logic bhe_n_reg, bhe_n_next;
  logic cs1_n_reg, cs1_n_next;
  logic cs2_n_reg, cs2_n_next;
  logic rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next;
  logic rsp_reg, rsp_next;
  logic err_reg, err_next;
  logic tmo_reg, tmo_next;
  logic irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic gate_ok;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign map_now = be_map(pci_be_n_i, port_16bit_i);
  assign gate_ok = pci_window_hit_i && second_window_enable_i && local_master_enable_i;
  assign wbyte = mreq_reg.wdata[{map_reg.la, 3'h0} +: 8];
  assign rbyte = map_reg.hi ? sync2_reg.data[15:8] : sync2_reg.data[7:0];

  always_comb begin
    m_next = m_reg;
    mreq_next = mreq_reg;
    map_next = map_reg;
    lat_next = (lat_reg != '0) ? lat_reg - 1'b1 : lat_reg;
    wait_next = wait_reg;
    la_next = la_reg;
    ldo_next = ldo_reg;
    bhe_n_next = bhe_n_reg;
    cs1_n_next = cs1_n_reg;
    cs2_n_next = cs2_n_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    rsp_next = 1'b0;
    err_next = err_reg;
    tmo_next = tmo_reg;
    irq_next = 1'b0;
    rdata_next = rdata_reg;
    case (m_reg)
      M_IDLE: begin
        if (pci_req_valid_i) begin
          mreq_next = '{write: pci_write_i, off: pci_offset_i, be_n: pci_be_n_i,
                        wdata: pci_wdata_i};
          map_next = map_now;
          tmo_next = 1'b0;
          if (!gate_ok) begin
            rsp_next = 1'b1;
            err_next = 1'b1;
          end else if (!map_now.ok || pci_offset_i[14:13] == `PAGE_BAD) begin
            rsp_next = 1'b1;
            err_next = 1'b1;
            irq_next = 1'b1;
          end else begin
            err_next = 1'b0;
            m_next = M_HOLD;
          end
        end
      end
      M_HOLD: begin
        if (sync2_reg.hlda) begin
          lat_next = LAT_CYC;
          la_next = {mreq_reg.off[12:2], map_reg.la};
          bhe_n_next = map_reg.bhe_n;
          cs1_n_next = !(mreq_reg.off[14:13] != `PAGE_1);
          cs2_n_next = !(mreq_reg.off[14:13] != `PAGE_0);
          if (map_reg.wide) begin
            ldo_next = map_reg.la[1] ? mreq_reg.wdata[31:16] : mreq_reg.wdata[15:0];
          end else begin
            ldo_next = map_reg.hi ? {wbyte, 8'h00} : {8'h00, wbyte};
          end
          m_next = M_ADDR;
        end
      end
      M_ADDR: begin
        rd_n_next = mreq_reg.write;
        wr_n_next = !mreq_reg.write;
        wait_next = WAIT_CYC;
        m_next = M_STRB;
      end
      M_STRB: begin
        if (!sync2_reg.rdy_n || wait_reg == '0) begin
          rd_n_next = 1'b1;
          wr_n_next = 1'b1;
          rsp_next = 1'b1;
          tmo_next = sync2_reg.rdy_n;
          rdata_next = map_reg.wide ? {2{sync2_reg.data}} : {4{rbyte}};
          m_next = M_DONE;
        end else begin
          wait_next = wait_reg - 1'b1;
        end
      end
      M_DONE: begin
        cs1_n_next = 1'b1;
        cs2_n_next = 1'b1;
        bhe_n_next = 1'b1;
        // bus is kept until the latency window closes
        if (lat_reg == '0) begin
          m_next = M_IDLE;
        end
      end
      default: m_next = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      m_reg <= M_IDLE;
      mreq_reg <= '0;
      map_reg <= '0;
      lat_reg <= '0;
      wait_reg <= '0;
      la_reg <= '0;
      ldo_reg <= '0;
      bhe_n_reg <= 1'b1;
      cs1_n_reg <= 1'b1;
      cs2_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rsp_reg <= 1'b0;
      err_reg <= 1'b0;
      tmo_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      m_reg <= m_next;
      mreq_reg <= mreq_next;
      map_reg <= map_next;
      lat_reg <= lat_next;
      wait_reg <= wait_next;
      la_reg <= la_next;
      ldo_reg <= ldo_next;
      bhe_n_reg <= bhe_n_next;
      cs1_n_reg <= cs1_n_next;
      cs2_n_reg <= cs2_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      rsp_reg <= rsp_next;
      err_reg <= err_next;
      tmo_reg <= tmo_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  logic m_bus;
  assign m_bus = (m_reg == M_ADDR) || (m_reg == M_STRB);
  assign pci_req_ready_o = (m_reg == M_IDLE);
  assign pci_rsp_valid_o = rsp_reg;
  assign pci_rsp_err_o = err_reg;
  assign pci_rsp_timeout_o = tmo_reg;
  assign pci_rdata_o = rdata_reg;
  assign access_error_o = irq_reg;
  assign hold_request_o = (m_reg != M_IDLE);
  assign local_address_o = la_reg;
  assign local_address_oe_o = m_bus;
  assign read_strobe_n_o = rd_n_reg;
  assign write_strobe_n_o = wr_n_reg;
  assign read_strobe_n_oe_o = m_bus;
  assign write_strobe_n_oe_o = m_bus;
  assign byte_high_enable_n_o = bhe_n_reg;
  assign page_chip_select_1_n_o = cs1_n_reg;
  assign page_chip_select_2_n_o = cs2_n_reg;
  assign local_data_o = m_bus ? ldo_reg : sdo_reg;
  assign local_data_oe_o = (m_bus && mreq_reg.write) || s_doe;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_take;
    m_reg == M_IDLE && pci_req_valid_i;
  endsequence
  sequence seq_grant;
    m_reg == M_HOLD && sync2_reg.hlda;
  endsequence

  a_master_gated: assert property (seq_take and !local_master_enable_i |=>
    m_reg == M_IDLE && pci_rsp_valid_o && pci_rsp_err_o) else $error("master ran while off");
  a_window_gated: assert property (seq_take and !second_window_enable_i |=>
    m_reg == M_IDLE && !access_error_o) else $error("window off yet cycle ran");
  a_page_decode: assert property (m_reg == M_STRB |->
    {cs2_n_reg, cs1_n_reg} == (mreq_reg.off[14:13] == `PAGE_0 ? 2'h2 :
    mreq_reg.off[14:13] == `PAGE_1 ? 2'h1 : 2'h0)) else $error("bad chip selects");
  a_slave_ready: assert property (s_reg == S_ACC && reg_ack_i |=>
    !local_ready_n_o && (s_doe == s_rd_reg) && sdo_reg == $past(reg_rdata_i))
    else $error("ready not given after ack");
  a_slave_release: assert property (s_reg == S_RDY && sync2_reg.rd_n && sync2_reg.wr_n |=>
    local_ready_n_o && !s_doe) else $error("slave kept bus after strobe");
  a_ready_float: assert property (sync2_reg.cs_n |-> !local_ready_n_oe_o)
    else $error("ready driven without select");
  a_hold_raise: assert property (seq_take and gate_ok and map_now.ok and
    pci_offset_i[14:13] != `PAGE_BAD |=> hold_request_o && m_reg == M_HOLD)
    else $error("no hold request");
  a_grant_start: assert property (seq_grant |=> m_reg == M_ADDR && lat_reg == LAT_CYC
    ##1 (read_strobe_n_o != write_strobe_n_o)) else $error("cycle not started on grant");
  a_hold_kept: assert property (hold_request_o && lat_reg != '0 |=> hold_request_o)
    else $error("hold dropped early");
  a_cycle_end: assert property (m_reg == M_ADDR |=> ##[1:260] m_reg == M_DONE)
    else $error("master cycle never ended");
  a_ready_end: assert property (m_reg == M_STRB && !sync2_reg.rdy_n |=>
    m_reg == M_DONE && read_strobe_n_o && write_strobe_n_o) else $error("ready ignored");
  a_bad_be: assert property (seq_take and gate_ok and !map_now.ok |=>
    access_error_o && m_reg == M_IDLE) else $error("illegal enables not refused");

endmodule : local_bus_sep_strobe_port

//--- sim/local_peer_model.sv
`timescale 1ns/1ps
// =====================================
// arbiter and ready-controlled peripheral
module local_peer_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // bench control
  input wire logic mute_i,
  input wire logic [1:0] dly_i,
  input wire logic [15:0] rdata_i,
  // local bus
  input wire logic hold_request_i,
  output logic hold_acknowledge_o,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [1:0] cs_n_i,
  input wire logic bhe_n_i,
  input wire logic [12:0] addr_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic ready_n_o,
  output logic ready_oe_o,
  // what the peripheral saw
  output logic [15:0] seen_o,
  output logic [15:0] seen_data_o,
  output int count_o
);
  logic act;
  logic act_q;
  logic [2:0] wcnt;
  // only a page select makes us respond, so slave traffic is ignored
  assign act = (cs_n_i != 2'h3) && !(rd_n_i && wr_n_i);
  assign data_o = rdata_i;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_acknowledge_o <= 1'h0;
      act_q <= 1'h0;
      wcnt <= 3'h0;
      data_oe_o <= 1'h0;
      ready_n_o <= 1'h1;
      ready_oe_o <= 1'h0;
      count_o <= 0;
      seen_o <= 16'h0000;
      seen_data_o <= 16'h0000;
    end else begin
      hold_acknowledge_o <= hold_request_i;
      act_q <= act;
      data_oe_o <= act && !rd_n_i;
      wcnt <= act ? wcnt + 3'h1 : 3'h0;
      ready_oe_o <= act;
      ready_n_o <= !(act && !mute_i && wcnt >= {1'h0, dly_i});
      if (act && !act_q) count_o <= count_o + 1;
      if (act) seen_o <= {cs_n_i, bhe_n_i, addr_i};
      if (act) seen_data_o <= data_i;
    end
  end
endmodule : local_peer_model

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench import lbus_pkg::*;;
  logic clk_sys_i = 1'h0;
  logic rstn_i = 1'h0;
  logic lme = 1'h0, win = 1'h0, hit = 1'h1, w16 = 1'h0, rq = 1'h0, pwr = 1'h0, ack = 1'h0;
  logic tcs = 1'h1, trd = 1'h1, twr = 1'h1, tdoe = 1'h0, mute = 1'h0;
  logic [14:0] poff = 15'h0000;
  logic [3:0] pbe = 4'hF;
  logic [31:0] pwd = 32'h0, prdata, seed;
  logic [15:0] rrd = 16'h0, td = 16'h0, prd = 16'h0, dlast = 16'h0, reg_wd, d_o, p_d, seen, seen_d;
  logic [12:0] ta = 13'h0, a_o;
  logic [11:0] reg_a;
  logic [1:0] dly = 2'h0;
  logic rq_rdy, rsp_v, rsp_e, rsp_t, aerr_p, reg_rd, reg_wr, local_clock_out, rd_o, rd_oe, wr_o, wr_oe;
  logic rdy_o, rdy_oe, a_oe, d_oe, hold, bhe, cs1, cs2, hack, p_doe, p_rdy, p_rdy_oe;
  int fails = 0, checks = 0, aerr = 0, holdbad = 0, pcnt;
  // =====================================
  // wire resolution, undriven data shows a changing pattern
  wire logic rd_w = rd_oe ? rd_o : trd;
  wire logic wr_w = wr_oe ? wr_o : twr;
  wire logic rdy_w = rdy_oe ? rdy_o : (p_rdy_oe ? p_rdy : 1'h1);
  wire logic [12:0] a_w = a_oe ? a_o : ta;
  wire logic [15:0] d_w = d_oe ? d_o : (p_doe ? p_d : (tdoe ? td : ~dlast));
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    dlast <= d_w;
    if (aerr_p) aerr <= aerr + 1;
    if (rstn_i && !(rd_w && wr_w) && (rd_oe || wr_oe) && !hold) holdbad <= holdbad + 1;
  end
  local_bus_sep_strobe_port #(.LAT_CYC(8'h04), .WAIT_CYC(8'h08)) u_dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .local_master_enable_i(lme),
    .second_window_enable_i(win), .port_16bit_i(w16), .pci_req_valid_i(rq),
    .pci_req_ready_o(rq_rdy), .pci_window_hit_i(hit), .pci_write_i(pwr), .pci_offset_i(poff),
    .pci_be_n_i(pbe), .pci_wdata_i(pwd), .pci_rsp_valid_o(rsp_v), .pci_rsp_err_o(rsp_e),
    .pci_rsp_timeout_o(rsp_t), .pci_rdata_o(prdata), .access_error_o(aerr_p),
    .reg_rd_o(reg_rd), .reg_wr_o(reg_wr), .reg_addr_o(reg_a), .reg_wdata_o(reg_wd),
    .reg_rdata_i(rrd), .reg_ack_i(ack), .local_clock_out_o(local_clock_out),
    .slave_chip_select_n_i(tcs), .read_strobe_n_i(rd_w), .read_strobe_n_o(rd_o),
    .read_strobe_n_oe_o(rd_oe), .write_strobe_n_i(wr_w), .write_strobe_n_o(wr_o),
    .write_strobe_n_oe_o(wr_oe), .local_ready_n_i(rdy_w), .local_ready_n_o(rdy_o),
    .local_ready_n_oe_o(rdy_oe), .local_address_i(a_w), .local_address_o(a_o),
    .local_address_oe_o(a_oe), .local_data_i(d_w), .local_data_o(d_o), .local_data_oe_o(d_oe),
    .hold_request_o(hold), .hold_acknowledge_i(hack), .byte_high_enable_n_o(bhe),
    .page_chip_select_1_n_o(cs1), .page_chip_select_2_n_o(cs2));
  local_peer_model u_peer (
    .clk_i(clk_sys_i), .rstn_i(rstn_i), .mute_i(mute), .dly_i(dly), .rdata_i(prd),
    .hold_request_i(hold), .hold_acknowledge_o(hack), .rd_n_i(rd_w), .wr_n_i(wr_w),
    .cs_n_i({cs2, cs1}), .bhe_n_i(bhe), .addr_i(a_w), .data_i(d_w), .data_o(p_d),
    .data_oe_o(p_doe), .ready_n_o(p_rdy), .ready_oe_o(p_rdy_oe), .seen_o(seen),
    .seen_data_o(seen_d), .count_o(pcnt));
  // =====================================
  // checking and control tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic lim(input int n);
    if (n > 200) begin
      fails++;
      $display("ERROR wait expected 200 seen %0d", n);
      stop_test();
    end
  endtask : lim
  function automatic be_map_t emap(input logic [3:0] be);
    be_map_t m;
    m = '{ok: 1'h1, la: 2'h0, bhe_n: 1'h1, hi: 1'h0, wide: 1'h0};
    case (be)
      4'hE: m.la = 2'h0;
      4'hD: begin m.la = 2'h1; m.hi = w16; end
      4'hB: m.la = 2'h2;
      4'h7: begin m.la = 2'h3; m.hi = w16; end
      4'hC: m.ok = w16;
      4'h3: begin m.la = 2'h2; m.ok = w16; end
      default: m.ok = 1'h0;
    endcase
    m.wide = w16 && (be == 4'hC || be == 4'h3);
    m.bhe_n = !(m.hi || m.wide);
    return m;
  endfunction : emap
  task automatic mcase(input logic wr, input logic [14:0] off, input logic [3:0] be);
    be_map_t m;
    int n, c, e;
    logic [7:0] b;
    logic [15:0] w;
    m = emap(be);
    c = pcnt;
    e = aerr;
    n = 0;
    @(negedge clk_sys_i);
    while (rq_rdy !== 1'h1) begin @(negedge clk_sys_i); n++; lim(n); end
    {pwr, poff, pbe, pwd, rq} = {wr, off, be, $urandom, 1'h1};
    prd = 16'($urandom);
    dly = 2'($urandom);
    b = pwd[8*m.la +: 8];
    w = m.la[1] ? pwd[31:16] : pwd[15:0];
    @(negedge clk_sys_i);
    rq = 1'h0;
    while (rsp_v !== 1'h1) begin @(negedge clk_sys_i); n++; lim(n); end
    if (!m.ok || off[14:13] == 2'h3 || !lme || !win || !hit) begin
      chk("rsp_err", rsp_e, 1'h1);
      @(negedge clk_sys_i);
      chk("cycles", pcnt, c);
      chk("access_error", aerr, e + ((lme && win && hit) ? 1 : 0));
      return;
    end
    chk("rsp_err", rsp_e, 1'h0);
    chk("timeout", rsp_t, mute);
    chk("cycles", pcnt, c + 1);
    chk("bus_ctl", seen, {off[14:13] == 2'h0, off[14:13] == 2'h1, m.bhe_n, off[12:2], m.la});
    if (wr && m.wide) chk("wdata", seen_d, w);
    else if (wr && m.hi) chk("wdata", seen_d[15:8], b);
    else if (wr) chk("wdata", seen_d[7:0], b);
    else if (!mute) chk("rdata", prdata, m.wide ? {2{prd}} : {4{m.hi ? prd[15:8] : prd[7:0]}});
  endtask : mcase
  task automatic slv(input logic wr, input logic [12:0] a);
    int n;
    logic [15:0] v;
    v = 16'($urandom);
    @(negedge clk_sys_i);
    {tcs, ta, td, tdoe, trd, twr} = {1'h0, a, 16'($urandom), wr, wr, !wr};
    n = 0;
    while ((wr ? reg_wr : reg_rd) !== 1'h1) begin @(negedge clk_sys_i); n++; lim(n); end
    chk("reg_addr", reg_a, a[12:1]);
    if (wr) chk("reg_wdata", reg_wd, td);
    rrd = v;
    ack = 1'h1;
    @(negedge clk_sys_i);
    ack = 1'h0;
    while (rdy_w !== 1'h0) begin @(negedge clk_sys_i); n++; lim(n); end
    if (!wr) chk("slave_rdata", d_w, v);
    {trd, twr, tdoe} = 3'h6;
    while (rdy_w !== 1'h1) begin @(negedge clk_sys_i); n++; lim(n); end
    chk("data_oe", d_oe, 1'h0);
  endtask : slv
  // =====================================
  // main sequence
  initial begin
    seed = $urandom(32'h80F5734A);
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rstn_i = 1'h1;
    repeat (3) @(negedge clk_sys_i);
    chk("local_clock", local_clock_out, clk_sys_i);
    mcase(1'h1, 15'h0000, 4'hE);
    lme = 1'h1;
    mcase(1'h0, 15'h2000, 4'hE);
    win = 1'h1;
    hit = 1'h0;
    mcase(1'h1, 15'h4000, 4'hE);
    hit = 1'h1;
    $display("test gating done");
    for (int k = 0; k < 64; k++) begin
      w16 = k[5];
      mcase(k[0], {2'(k % 3), 13'($urandom)}, 4'(k >> 1));
    end
    mcase(1'h1, {2'h3, 13'($urandom)}, 4'hE);
    $display("test byte map done");
    mute = 1'h1;
    mcase(1'h0, 15'h4000, 4'hC);
    mute = 1'h0;
    $display("test wait timer done");
    // select stays low across all accesses
    for (int k = 0; k < 12; k++) slv(k[0], 13'($urandom));
    tcs = 1'h1;
    repeat (4) @(negedge clk_sys_i);
    chk("ready_oe", rdy_oe, 1'h0);
    chk("hold_in_cycle", holdbad, 0);
    $display("test slave done");
    stop_test();
  end
endmodule : testbench
